// >>> hdl/fpu_trap_defs.svh
// Constants for the floating-point availability trap: bit positions, vectors, reset values
`ifndef FPU_TRAP_DEFS_SVH
`define FPU_TRAP_DEFS_SVH

// Machine control register layout
`define CTRL_EMULATION_BIT     2
`define CTRL_TASK_SWITCHED_BIT 3
`define CTRL_NATIVE_ERROR_BIT  5
`define CTRL_RESET      32'h0000_0000

// Exception vectors
`define VEC_UD          8'h06
`define VEC_DEV_NOT_AVAIL 8'h07
`define VEC_NUMERIC     8'h10
`define VEC_NONE        8'h00

// Pending floating-point exception flags
`define FLAG_W          6
`define FLAGS_CLEAR     6'h00

`endif

// >>> hdl/fpu_trap_pkg.sv
// Types shared by the floating-point availability trap modules
package fpu_trap_pkg;

  // Class of the instruction offered at issue, one-hot
  typedef enum logic [4:0] {
    CLASS_OTHER   = 5'h01,
    CLASS_FLOAT   = 5'h02,
    CLASS_NOWAIT  = 5'h04,
    CLASS_RESTORE = 5'h08,
    CLASS_PACKED  = 5'h10
  } instr_class_type;

  // What happens to the offered instruction, one-hot
  typedef enum logic [3:0] {
    OUT_EXEC      = 4'h1,
    OUT_NOT_AVAIL = 4'h2,
    OUT_UD        = 4'h4,
    OUT_NUMERIC   = 4'h8
  } outcome_type;

endpackage

// >>> hdl/trap_if.sv
// Interface between the trap core and its priority decision
`timescale 1ns/1ps
`default_nettype none

interface trap_if;
  fpu_trap_pkg::instr_class_type cls;
  logic                          task_switched_flag;
  logic                          emulation_flag;
  logic                          native_error_select;
  logic                          pend;
  fpu_trap_pkg::outcome_type     outcome;

  modport decide (input  cls, input  task_switched_flag, input  emulation_flag, input  native_error_select,
                  input  pend, output outcome);
  modport core   (output cls, output task_switched_flag, output emulation_flag, output native_error_select,
                  output pend, input  outcome);
endinterface

`default_nettype wire

// >>> hdl/trap_priority.sv
// Priority decision for an offered instruction: invalid opcode, availability fault, numeric error
`timescale 1ns/1ps
`default_nettype none

module trap_priority (
  trap_if.decide t
);

  logic fp_class;

  // Waiting and no-wait float forms all depend on unit availability
  assign fp_class = (t.cls == fpu_trap_pkg::CLASS_FLOAT) || (t.cls == fpu_trap_pkg::CLASS_NOWAIT) ||
                    (t.cls == fpu_trap_pkg::CLASS_RESTORE);

  // Availability fault beats numeric, so a pending error is taken in its own context
  always_comb begin
    t.outcome = fpu_trap_pkg::OUT_EXEC;
    if (t.cls == fpu_trap_pkg::CLASS_PACKED && t.emulation_flag) begin
      t.outcome = fpu_trap_pkg::OUT_UD;
    end else if ((fp_class && (t.task_switched_flag || t.emulation_flag)) ||
                 (t.cls == fpu_trap_pkg::CLASS_PACKED && t.task_switched_flag)) begin
      t.outcome = fpu_trap_pkg::OUT_NOT_AVAIL;
    end else if (t.native_error_select && t.pend && t.cls != fpu_trap_pkg::CLASS_NOWAIT && fp_class) begin
      t.outcome = fpu_trap_pkg::OUT_NUMERIC;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/fpu_availability_trap.sv
// Floating-point availability trap: switch flag, emulation flag and pending numeric errors
// What this block does
// - Hardware task switch sets switch flag bit 3
// - Switch flag set: float instruction faults vector 7
// - Fault is restartable; instruction re-executes after return
// - Emulation flag bit 2 also forces vector 7
// - Emulation flag: packed-integer ops raise invalid opcode
// - Numeric error signalled before next float instruction
// - Native reporting off: interrupt around no-wait save
// - Restore reinstates pending flags, error signals again
// - Availability fault beats pending numeric exception
// - Clearing no-wait save drops errors and error output
`timescale 1ns/1ps
`default_nettype none
`include "fpu_trap_defs.svh"

module fpu_availability_trap (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Machine control register access
  input  wire logic                          ctrl_wr,
  input  wire logic [31:0]                   ctrl_wdata,
  output logic      [31:0]                   ctrl_rdata,
  // Task switch events
  input  wire logic                          hw_task_switch,
  input  wire logic                          clear_switch_flag_instruction,
  // Instruction issue
  input  wire logic                          issue_valid,
  input  wire fpu_trap_pkg::instr_class_type issue_class,
  input  wire logic [`FLAG_W-1:0]            restore_flags,
  // Numeric results from execution
  input  wire logic                          exec_exc_valid,
  input  wire logic [`FLAG_W-1:0]            exec_exc_flags,
  // Outcome
  output logic                               issue_accept,
  output logic                               fault_valid,
  output logic      [7:0]                    fault_vector,
  output logic                               float_error_output,
  output logic      [`FLAG_W-1:0]            pending_flags
);

  logic [31:0]          ctrl_reg;
  logic [31:0]          ctrl_next;
  logic [`FLAG_W-1:0]   pend_reg;
  logic [`FLAG_W-1:0]   pend_next;
  logic                 accept_reg;
  logic                 fault_reg;
  logic [7:0]           vector_reg;
  logic                 err_reg;
  logic                 run_now;
  logic                 fp_issue;

  trap_if tif ();

  // Hand the live flags to the priority decision
  assign tif.cls  = issue_class;
  assign tif.task_switched_flag  = ctrl_reg[`CTRL_TASK_SWITCHED_BIT];
  assign tif.emulation_flag      = ctrl_reg[`CTRL_EMULATION_BIT];
  assign tif.native_error_select = ctrl_reg[`CTRL_NATIVE_ERROR_BIT];
  assign tif.pend = |pend_reg;

  trap_priority u_priority (
    .t (tif.decide)
  );

  assign run_now  = issue_valid && (tif.outcome == fpu_trap_pkg::OUT_EXEC);
  assign fp_issue = (issue_class == fpu_trap_pkg::CLASS_FLOAT) || (issue_class == fpu_trap_pkg::CLASS_NOWAIT) ||
                    (issue_class == fpu_trap_pkg::CLASS_RESTORE);

  // Control register: write, then clear, then hardware set; the set wins a same-cycle clear
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next = ctrl_wdata;
    end
    if (clear_switch_flag_instruction) begin
      ctrl_next[`CTRL_TASK_SWITCHED_BIT] = 1'b0;
    end
    if (hw_task_switch) begin
      ctrl_next[`CTRL_TASK_SWITCHED_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= `CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Pending flags: faulted instructions leave them untouched, so a retry sees the same state
  always_comb begin
    pend_next = pend_reg;
    if (run_now && issue_class == fpu_trap_pkg::CLASS_NOWAIT) begin
      pend_next = `FLAGS_CLEAR;
    end
    if (run_now && issue_class == fpu_trap_pkg::CLASS_RESTORE) begin
      pend_next = restore_flags;
    end
    if (exec_exc_valid) begin
      pend_next = pend_next | exec_exc_flags;                            // New errors win over a clear
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= `FLAGS_CLEAR;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // Error output follows pending flags; with native reporting off, the outside
  // interrupt path adds its own delay, which may land after a no-wait save
  always_ff @(posedge clk) begin
    if (rst) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= |pend_next;
    end
  end

  // Outcome pulses: a fault never accepts, so the core re-issues on return
  always_ff @(posedge clk) begin
    if (rst) begin
      accept_reg <= 1'b0;
      fault_reg  <= 1'b0;
      vector_reg <= `VEC_NONE;
    end else begin
      accept_reg <= run_now;
      fault_reg  <= issue_valid && !run_now;
      case (tif.outcome)
        fpu_trap_pkg::OUT_NOT_AVAIL: vector_reg <= issue_valid ? `VEC_DEV_NOT_AVAIL : `VEC_NONE;
        fpu_trap_pkg::OUT_UD:        vector_reg <= issue_valid ? `VEC_UD : `VEC_NONE;
        fpu_trap_pkg::OUT_NUMERIC:   vector_reg <= issue_valid ? `VEC_NUMERIC : `VEC_NONE;
        default:                     vector_reg <= `VEC_NONE;
      endcase
    end
  end

  assign ctrl_rdata         = ctrl_reg;
  assign pending_flags      = pend_reg;
  assign float_error_output = err_reg;
  assign issue_accept       = accept_reg;
  assign fault_valid        = fault_reg;
  assign fault_vector       = vector_reg;

  // Checks on flag handling and fault choice
  switch_set_a: assert property (@(posedge clk) disable iff (rst)
    hw_task_switch |=> ctrl_reg[`CTRL_TASK_SWITCHED_BIT])
    else $error("task switch did not set switch flag");

  not_avail_fault_a: assert property (@(posedge clk) disable iff (rst)
    issue_valid && fp_issue && ctrl_reg[`CTRL_TASK_SWITCHED_BIT]
    |=> fault_valid && fault_vector == `VEC_DEV_NOT_AVAIL)
    else $error("switch flag set but no vector 7 fault");

  fault_keeps_state_a: assert property (@(posedge clk) disable iff (rst)
    issue_valid && fp_issue && ctrl_reg[`CTRL_TASK_SWITCHED_BIT] && !exec_exc_valid
    |=> pend_reg == $past(pend_reg))
    else $error("faulting instruction changed pending flags");

  fault_restart_a: assert property (@(posedge clk) disable iff (rst)
    fault_valid |-> !issue_accept && fault_vector != `VEC_NONE)
    else $error("faulted instruction accepted or given no vector");

  emul_fault_a: assert property (@(posedge clk) disable iff (rst)
    issue_valid && fp_issue && ctrl_reg[`CTRL_EMULATION_BIT] |=> fault_vector == `VEC_DEV_NOT_AVAIL)
    else $error("emulation flag did not force vector 7");

  emul_packed_a: assert property (@(posedge clk) disable iff (rst)
    issue_valid && issue_class == fpu_trap_pkg::CLASS_PACKED && ctrl_reg[`CTRL_EMULATION_BIT]
    |=> fault_valid && fault_vector == `VEC_UD)
    else $error("packed op under emulation not invalid opcode");

  numeric_next_a: assert property (@(posedge clk) disable iff (rst)
    issue_valid && issue_class == fpu_trap_pkg::CLASS_FLOAT && !ctrl_reg[`CTRL_TASK_SWITCHED_BIT] &&
    !ctrl_reg[`CTRL_EMULATION_BIT] && ctrl_reg[`CTRL_NATIVE_ERROR_BIT] && (|pend_reg)
    |=> fault_vector == `VEC_NUMERIC)
    else $error("pending error not signalled on next float op");

  nowait_clear_a: assert property (@(posedge clk) disable iff (rst)
    run_now && issue_class == fpu_trap_pkg::CLASS_NOWAIT && !exec_exc_valid
    |=> pend_reg == `FLAGS_CLEAR && !float_error_output)
    else $error("no-wait save left errors pending");

  restore_reload_a: assert property (@(posedge clk) disable iff (rst)
    run_now && issue_class == fpu_trap_pkg::CLASS_RESTORE && !exec_exc_valid
    |=> pend_reg == $past(restore_flags) ##0 float_error_output == (|$past(restore_flags)))
    else $error("restore did not reinstate flags");

  not_avail_first_a: assert property (@(posedge clk) disable iff (rst)
    issue_valid && issue_class == fpu_trap_pkg::CLASS_FLOAT && ctrl_reg[`CTRL_TASK_SWITCHED_BIT] &&
    ctrl_reg[`CTRL_NATIVE_ERROR_BIT] && (|pend_reg) |=> fault_vector == `VEC_DEV_NOT_AVAIL)
    else $error("numeric fault beat availability fault");

endmodule

`default_nettype wire

// >>> tb/fpu_availability_trap_tb.sv
// Self-checking bench for the floating-point availability trap, with a cycle model
`timescale 1ns/1ps
`default_nettype none
`include "fpu_trap_defs.svh"

module fpu_availability_trap_tb;
  logic                          clk = 1'b0;
  logic                          rst = 1'b1;
  logic                          ctrl_wr = 1'b0;
  logic                          hw = 1'b0;
  logic                          clr = 1'b0;
  logic                          iv = 1'b0;
  logic                          ev = 1'b0;
  logic [31:0]                   wdata = 32'h0000_0000;
  fpu_trap_pkg::instr_class_type cls = fpu_trap_pkg::CLASS_OTHER;
  logic [`FLAG_W-1:0]            rfl = 6'h00;
  logic [`FLAG_W-1:0]            efl = 6'h00;
  logic [31:0]                   rdata;
  logic                          acc;
  logic                          flt;
  logic                          err_out;
  logic [7:0]                    vec;
  logic [`FLAG_W-1:0]            pend;
  // Model state and bookkeeping
  logic [31:0]                   m_ctrl;
  logic [`FLAG_W-1:0]            m_pend;
  logic                          m_acc;
  logic                          m_flt;
  logic [7:0]                    m_vec;
  logic [31:0]                   seed = 32'h7E14;
  logic [31:0]                   r;
  int                            n_fail = 0;
  int                            tests_run = 0;

  fpu_availability_trap uut (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(wdata), .ctrl_rdata(rdata),
    .hw_task_switch(hw), .clear_switch_flag_instruction(clr), .issue_valid(iv), .issue_class(cls),
    .restore_flags(rfl), .exec_exc_valid(ev), .exec_exc_flags(efl), .issue_accept(acc), .fault_valid(flt),
    .fault_vector(vec), .float_error_output(err_out), .pending_flags(pend));

  // Free-running core clock, 50 ns period
  initial forever #25 clk = ~clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check_ctrl(logic [31:0] e);
    tests_run++;
    if (rdata !== e) begin
      n_fail++;
      $display("mismatch at %0t: control %h expected %h", $time, rdata, e);
    end
  endtask

  task automatic check_issue(logic a, logic f, logic [7:0] v);
    tests_run++;
    if (acc !== a || flt !== f || vec !== v) begin
      n_fail++;
      $display("mismatch at %0t: outcome %b%b %h expected %b%b %h", $time, acc, flt, vec, a, f, v);
    end
  endtask

  task automatic check_pend(logic [`FLAG_W-1:0] p);
    tests_run++;
    if (pend !== p || err_out !== (p != 6'h00)) begin
      n_fail++;
      $display("mismatch at %0t: pending %h error %b expected %h", $time, pend, err_out, p);
    end
  endtask

  // One cycle: drive at the falling edge, model the rising edge, compare at the next falling edge
  task automatic cyc(logic w, logic [31:0] wd, logic h, logic c, logic i, logic [4:0] k,
                     logic [5:0] rf, logic e, logic [5:0] ef);
    logic [7:0] v;
    ctrl_wr = w; wdata = wd; hw = h; clr = c; iv = i;
    cls = fpu_trap_pkg::instr_class_type'(k); rfl = rf; ev = e; efl = ef;
    @(posedge clk);
    v = 8'h00;
    if (rst) begin
      m_ctrl = 32'h0000_0000; m_pend = 6'h00; m_acc = 1'b0; m_flt = 1'b0; m_vec = 8'h00;
    end else begin
      if (i && k[4] && m_ctrl[`CTRL_EMULATION_BIT])
        v = `VEC_UD;
      else if (i && (|(k & 5'h0E) && (m_ctrl[`CTRL_TASK_SWITCHED_BIT] || m_ctrl[`CTRL_EMULATION_BIT]) ||
                     k[4] && m_ctrl[`CTRL_TASK_SWITCHED_BIT]))
        v = `VEC_DEV_NOT_AVAIL;
      else if (i && |(k & 5'h0A) && m_ctrl[`CTRL_NATIVE_ERROR_BIT] && m_pend != 6'h00)
        v = `VEC_NUMERIC;
      m_flt = (v != 8'h00); m_acc = i && !m_flt; m_vec = v;
      // A faulted instruction leaves the flags alone; a late exception still lands
      if (m_acc && k[2]) m_pend = 6'h00;
      if (m_acc && k[3]) m_pend = rf;
      if (e) m_pend = m_pend | ef;
      if (w) m_ctrl = wd;
      if (c) m_ctrl[`CTRL_TASK_SWITCHED_BIT] = 1'b0;
      if (h) m_ctrl[`CTRL_TASK_SWITCHED_BIT] = 1'b1;
    end
    @(negedge clk);
    check_ctrl(m_ctrl);
    check_issue(m_acc, m_flt, m_vec);
    check_pend(m_pend);
  endtask

  // Watchdog against a hung run
  initial begin
    #(1000000);
    n_fail++;
    finish_test();
  end

  initial begin
    @(negedge clk);
    repeat (20) cyc(0, 0, 0, 0, 0, 5'h01, 0, 0, 0);
    rst = 1'b0;
    cyc(0, 0, 1, 0, 0, 5'h01, 0, 0, 0);
    cyc(0, 0, 0, 0, 1, 5'h02, 0, 0, 0);
    cyc(0, 0, 0, 1, 1, 5'h02, 0, 0, 0);
    cyc(0, 0, 0, 0, 1, 5'h02, 0, 0, 0);
    $display("test hardware switch done");
    cyc(1, 32'h0000_0028, 0, 0, 0, 5'h01, 0, 0, 0);
    cyc(0, 0, 0, 0, 1, 5'h10, 0, 0, 0);
    cyc(1, 32'h0000_0020, 0, 0, 1, 5'h08, 6'h01, 1, 6'h04);
    cyc(0, 0, 0, 0, 1, 5'h02, 0, 0, 0);
    cyc(0, 0, 0, 0, 1, 5'h10, 0, 0, 0);
    // Kernel-owned swap: the save drops the old errors, the restore brings the next thread's full image
    cyc(0, 0, 0, 0, 1, 5'h04, 0, 0, 0);
    cyc(0, 0, 0, 0, 1, 5'h08, 6'h01, 0, 0);
    cyc(0, 0, 1, 0, 1, 5'h02, 0, 0, 0);
    cyc(0, 0, 0, 0, 1, 5'h02, 0, 0, 0);
    cyc(1, 32'h0000_0024, 0, 0, 1, 5'h04, 0, 0, 0);
    cyc(0, 0, 0, 0, 1, 5'h10, 0, 0, 0);
    cyc(0, 0, 0, 0, 1, 5'h02, 0, 0, 0);
    $display("test directed traps done");
    // Random traffic, with a reset in mid-run
    for (int n = 0; n < 3000; n++) begin
      r = xs();
      rst = (n >= 1500 && n < 1503);
      cyc(r[3:0] == 4'h0, xs(), r[6:4] == 3'h7, r[9:7] == 3'h7, r[10], 5'h01 << (r[15:12] % 5),
          r[21:16], r[23:22] == 2'h3, r[29:24]);
    end
    $display("test random traffic done");
    finish_test();
  end
endmodule

`default_nettype wire
